// *** hw/cbx_pkg.sv ***
// Shared constants, types and decode function for the execution block
package cbx_pkg;

    // ========================================================================
    // Widths
    localparam int INSTR_W = 14;
    localparam int DATA_W  = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W    = 15;
    localparam int K_W     = 11;
    localparam int ADDR_W  = 8;
    localparam int LATCH_W = 7;

    // ========================================================================
    // Instruction fields
    localparam int OPC6_MSB = 13;
    localparam int OPC6_LSB = 8;
    localparam int OPC3_LSB = 11;
    localparam int D_BIT    = 7;
    localparam int F_MSB    = 6;
    localparam int K_MSB    = 10;
    localparam int LIT_MSB  = 7;

    // ========================================================================
    // Opcode encodings
    localparam logic [2:0] OPC_JUMP      = 3'h5;
    localparam logic [5:0] OPC_BUMP      = 6'h0A;
    localparam logic [5:0] OPC_BUMP_SKIP = 6'h0F;
    localparam logic [5:0] OPC_OR_FILE   = 6'h04;
    localparam logic [5:0] OPC_SHL       = 6'h35;
    localparam logic [5:0] OPC_SHR       = 6'h36;
    localparam logic [5:0] OPC_OR_LIT    = 6'h38;

    // ========================================================================
    // Upper address latch field feeding the jump target
    localparam int LATCH_JMP_MSB = 6;
    localparam int LATCH_JMP_LSB = 3;

    // ========================================================================
    // Register map
    localparam logic [ADDR_W-1:0] REG_FILE_TOP = 8'h7F;
    localparam logic [ADDR_W-1:0] REG_ACC      = 8'h80;
    localparam logic [ADDR_W-1:0] REG_FLAGS    = 8'h81;
    localparam logic [ADDR_W-1:0] REG_LATCH    = 8'h82;
    localparam logic [ADDR_W-1:0] REG_PC_LO    = 8'h83;
    localparam logic [ADDR_W-1:0] REG_PC_HI    = 8'h84;
    localparam int FLAG_C_BIT = 0;
    localparam int FLAG_Z_BIT = 1;

    // ========================================================================
    // Reset values and timing
    localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
    localparam logic [DATA_W-1:0]  FILE_RST  = 8'h00;
    localparam logic [PC_W-1:0]    PC_RST    = 15'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RST = 7'h00;
    localparam int CYCLE_DIV = 4;

    typedef enum logic [2:0] {
        OP_IDLE      = 3'b000,
        OP_JUMP      = 3'b001,
        OP_BUMP      = 3'b010,
        OP_BUMP_SKIP = 3'b011,
        OP_OR_LIT    = 3'b100,
        OP_OR_FILE   = 3'b101,
        OP_SHL       = 3'b110,
        OP_SHR       = 3'b111
    } cbx_op_t;

    typedef enum logic [0:0] {
        ST_EXEC  = 1'b0,
        ST_FLUSH = 1'b1
    } cbx_state_t;

    // ========================================================================
    // Decode
    function automatic cbx_op_t cbx_decode(input logic [INSTR_W-1:0] instr);
        logic [5:0] opc6;
        opc6 = instr[OPC6_MSB:OPC6_LSB];
        if (instr[OPC6_MSB:OPC3_LSB] == OPC_JUMP)  return OP_JUMP;
        else if (opc6 == OPC_BUMP)                 return OP_BUMP;
        else if (opc6 == OPC_BUMP_SKIP)            return OP_BUMP_SKIP;
        else if (opc6 == OPC_OR_LIT)               return OP_OR_LIT;
        else if (opc6 == OPC_OR_FILE)              return OP_OR_FILE;
        else if (opc6 == OPC_SHL)                  return OP_SHL;
        else if (opc6 == OPC_SHR)                  return OP_SHR;
        else                                       return OP_IDLE;
    endfunction : cbx_decode

endpackage : cbx_pkg

// *** hw/cbx_alu_if.sv ***
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
interface cbx_alu_if;
    import cbx_pkg::*;
    cbx_op_t            op;
    logic [DATA_W-1:0]  f_val;
    logic [DATA_W-1:0]  acc;
    logic [DATA_W-1:0]  lit;
    logic [DATA_W-1:0]  result;
    logic               carry;
    logic               zero;
    logic               upd_zero;
    logic               upd_carry;
    logic               skip_hit;
    modport core (output op, f_val, acc, lit,
                  input  result, carry, zero, upd_zero, upd_carry, skip_hit);
    modport alu  (input  op, f_val, acc, lit,
                  output result, carry, zero, upd_zero, upd_carry, skip_hit);
endinterface : cbx_alu_if

// *** hw/cbx_alu.sv ***
// Combinational result and flag logic for the supported operations
`timescale 1ns/1ps
module cbx_alu
    import cbx_pkg::*;
(
    cbx_alu_if.alu alu
);

    // ========================================================================
    // Result
    always_comb begin
        alu.result    = alu.f_val;
        alu.carry     = 1'b0;
        alu.upd_zero  = 1'b0;
        alu.upd_carry = 1'b0;
        case (alu.op)
            OP_BUMP: begin
                alu.result   = DATA_W'(alu.f_val + 8'h01);
                alu.upd_zero = 1'b1;
            end
            OP_BUMP_SKIP: begin
                // No flag update here
                alu.result = DATA_W'(alu.f_val + 8'h01);
            end
            OP_OR_LIT: begin
                alu.result   = alu.acc | alu.lit;
                alu.upd_zero = 1'b1;
            end
            OP_OR_FILE: begin
                alu.result   = alu.acc | alu.f_val;
                alu.upd_zero = 1'b1;
            end
            OP_SHL: begin
                alu.result    = {alu.f_val[DATA_W-2:0], 1'b0};
                alu.carry     = alu.f_val[DATA_W-1];
                alu.upd_zero  = 1'b1;
                alu.upd_carry = 1'b1;
            end
            OP_SHR: begin
                alu.result    = {1'b0, alu.f_val[DATA_W-1:1]};
                alu.carry     = alu.f_val[0];
                alu.upd_zero  = 1'b1;
                alu.upd_carry = 1'b1;
            end
            default: begin
                alu.result = alu.f_val;
            end
        endcase
    end

    // ========================================================================
    // Flags
    assign alu.zero     = (alu.result == '0);
    assign alu.skip_hit = (alu.op == OP_BUMP_SKIP) && alu.zero;

endmodule : cbx_alu

// *** hw/cbx_core.sv ***
// Execution core for jump, increment, skip, OR and shift operations
`timescale 1ns/1ps
module cbx_core
    import cbx_pkg::*;
#(
    parameter int CLK_PER_CYCLE = CYCLE_DIV
) (
    input  wire logic               I_CLOCK,
    input  wire logic               I_NRST,
    input  wire logic               I_INSTR_VALID,
    input  wire logic [INSTR_W-1:0] I_INSTR,
    input  wire logic [ADDR_W-1:0]  I_ADDR,
    input  wire logic [DATA_W-1:0]  I_WDATA,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    output logic      [DATA_W-1:0]  O_RDATA,
    output logic      [PC_W-1:0]    O_PC,
    output logic      [DATA_W-1:0]  O_ACC,
    output logic                    O_ZERO,
    output logic                    O_CARRY,
    output logic                    O_FLUSH,
    output logic                    O_RETIRE
);

    // ========================================================================
    // Reset release
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge I_CLOCK or negedge I_NRST) begin
        if (!I_NRST) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ========================================================================
    // Instruction cycle enable
    localparam int DIV_W = $clog2(CLK_PER_CYCLE + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_PER_CYCLE - 1);

    logic [DIV_W-1:0] div_cnt;
    logic             cyc_en;

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            cyc_en  <= 1'b0;
        end else begin
            cyc_en <= (div_cnt == DIV_LAST);
            if (div_cnt == DIV_LAST) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= DIV_W'(div_cnt + 1'b1);
            end
        end
    end

    // ========================================================================
    // Architectural state
    logic [DATA_W-1:0]  file_mem [2**FADDR_W];
    logic [DATA_W-1:0]  acc;
    logic               zero_flag;
    logic               carry_flag;
    logic [LATCH_W-1:0] latch;
    logic [PC_W-1:0]    pc;
    cbx_state_t         state;
    cbx_state_t         next_state;
    logic               flush_is_skip;

    // ========================================================================
    // Operand fetch and decode
    cbx_op_t            op;
    logic [FADDR_W-1:0] f_addr;
    logic               to_file;
    logic               exec;
    logic               uses_file;

    assign op      = cbx_decode(I_INSTR);
    assign f_addr  = I_INSTR[F_MSB:0];
    assign to_file = I_INSTR[D_BIT] && uses_file;
    assign exec    = cyc_en && (state == ST_EXEC) && I_INSTR_VALID;
    assign uses_file = (op == OP_BUMP) || (op == OP_BUMP_SKIP) || (op == OP_OR_FILE)
                    || (op == OP_SHL) || (op == OP_SHR);

    cbx_alu_if alu_bus ();

    assign alu_bus.op    = op;
    assign alu_bus.f_val = file_mem[f_addr];
    assign alu_bus.acc   = acc;
    assign alu_bus.lit   = I_INSTR[LIT_MSB:0];

    cbx_alu u_alu (
        .alu (alu_bus)
    );

    // ========================================================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            ST_EXEC: begin
                if (exec && ((op == OP_JUMP) || alu_bus.skip_hit)) begin
                    next_state = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (cyc_en) begin
                    next_state = ST_EXEC;
                end
            end
            default: begin
                next_state = ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            state         <= ST_EXEC;
            flush_is_skip <= 1'b0;
        end else begin
            state <= next_state;
            if (exec) begin
                flush_is_skip <= alu_bus.skip_hit;
            end
        end
    end

    // ========================================================================
    // Program counter
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            pc <= PC_RST;
        end else if (exec && (op == OP_JUMP)) begin
            pc <= {latch[LATCH_JMP_MSB:LATCH_JMP_LSB], I_INSTR[K_MSB:0]};
        end else if (exec) begin
            pc <= PC_W'(pc + 1'b1);
        end else if (cyc_en && (state == ST_FLUSH) && flush_is_skip) begin
            // Skipped word is discarded, so step past it
            pc <= PC_W'(pc + 1'b1);
        end
    end

    // ========================================================================
    // Accumulator; execution wins over a software write in the same cycle
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            acc <= ACC_RST;
        end else if (exec && uses_file && !to_file) begin
            acc <= alu_bus.result;
        end else if (exec && (op == OP_OR_LIT)) begin
            acc <= alu_bus.result;
        end else if (I_WR && (I_ADDR == REG_ACC)) begin
            acc <= I_WDATA;
        end
    end

    // ========================================================================
    // Status flags
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag  <= 1'b0;
            carry_flag <= 1'b0;
        end else if (exec && (alu_bus.upd_zero || alu_bus.upd_carry)) begin
            if (alu_bus.upd_zero) begin
                zero_flag <= alu_bus.zero;
            end
            if (alu_bus.upd_carry) begin
                carry_flag <= alu_bus.carry;
            end
        end else if (I_WR && (I_ADDR == REG_FLAGS)) begin
            zero_flag  <= I_WDATA[FLAG_Z_BIT];
            carry_flag <= I_WDATA[FLAG_C_BIT];
        end
    end

    // ========================================================================
    // Upper address latch, written only by software
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            latch <= LATCH_RST;
        end else if (I_WR && (I_ADDR == REG_LATCH)) begin
            latch <= I_WDATA[LATCH_W-1:0];
        end
    end

    // ========================================================================
    // File registers
    for (genvar gi = 0; gi < 2**FADDR_W; gi++) begin : g_file
        always_ff @(posedge I_CLOCK or negedge rst_n) begin
            if (!rst_n) begin
                file_mem[gi] <= FILE_RST;
            end else if (exec && to_file && (f_addr == FADDR_W'(gi))) begin
                file_mem[gi] <= alu_bus.result;
            end else if (I_WR && (I_ADDR == ADDR_W'(gi))) begin
                file_mem[gi] <= I_WDATA;
            end
        end
    end

    // ========================================================================
    // Register read port, data one cycle after the strobe
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_RDATA <= '0;
        end else if (!I_RD) begin
            O_RDATA <= '0;
        end else if (I_ADDR <= REG_FILE_TOP) begin
            O_RDATA <= file_mem[I_ADDR[FADDR_W-1:0]];
        end else if (I_ADDR == REG_ACC) begin
            O_RDATA <= acc;
        end else if (I_ADDR == REG_FLAGS) begin
            O_RDATA <= DATA_W'({zero_flag, carry_flag});
        end else if (I_ADDR == REG_LATCH) begin
            O_RDATA <= DATA_W'(latch);
        end else if (I_ADDR == REG_PC_LO) begin
            O_RDATA <= pc[DATA_W-1:0];
        end else if (I_ADDR == REG_PC_HI) begin
            O_RDATA <= DATA_W'(pc[PC_W-1:DATA_W]);
        end else begin
            O_RDATA <= '0;
        end
    end

    // ========================================================================
    // Outputs
    always_ff @(posedge I_CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            O_RETIRE <= 1'b0;
        end else begin
            O_RETIRE <= exec;
        end
    end

    assign O_PC    = pc;
    assign O_ACC   = acc;
    assign O_ZERO  = zero_flag;
    assign O_CARRY = carry_flag;
    assign O_FLUSH = state;

    // ========================================================================
    // Checks
    logic [DATA_W-1:0] f_now;
    assign f_now = file_mem[f_addr];

    chk_jump_low: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_JUMP |=> pc[K_MSB:0] == $past(I_INSTR[K_MSB:0]))
        else $error("jump low address wrong");
    chk_jump_high: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_JUMP |=> pc[PC_W-1:K_W] == $past(latch[LATCH_JMP_MSB:LATCH_JMP_LSB]))
        else $error("jump high address wrong");
    chk_jump_two: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_JUMP |=> state == ST_FLUSH && $stable(zero_flag)
            && $stable(carry_flag) ##1 (state == ST_FLUSH)[*3] ##1 state == ST_EXEC)
        else $error("jump not two cycles or flags moved");
    chk_dest_acc: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && uses_file && !I_INSTR[D_BIT] |=> acc == $past(alu_bus.result)
            && file_mem[$past(f_addr)] == $past(f_now))
        else $error("destination accumulator wrong");
    chk_bump_file: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_BUMP && I_INSTR[D_BIT] |=>
            file_mem[$past(f_addr)] == DATA_W'($past(f_now) + 8'h01))
        else $error("increment to file wrong");
    chk_skip_taken: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_BUMP_SKIP && f_now == 8'hFF |=> state == ST_FLUSH
            ##4 pc == PC_W'($past(pc, 5) + 15'h0002))
        else $error("zero skip not taken");
    chk_skip_flags: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_BUMP_SKIP |=> $stable(zero_flag) && $stable(carry_flag)
            && (state == ST_FLUSH) == ($past(f_now) == 8'hFF))
        else $error("skip changed flags or path");
    chk_or_lit: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_OR_LIT |=> acc == ($past(acc) | $past(I_INSTR[LIT_MSB:0])))
        else $error("literal OR wrong");
    chk_or_file: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_OR_FILE && !I_INSTR[D_BIT] |=> acc == ($past(acc) | $past(f_now)))
        else $error("register OR wrong");
    chk_shift_left: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHL |=> carry_flag == $past(f_now[DATA_W-1])
            && zero_flag == ($past(f_now[DATA_W-2:0]) == 7'h00))
        else $error("left shift flags wrong");
    chk_shift_right: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHR |=> carry_flag == $past(f_now[0])
            && zero_flag == ($past(f_now[DATA_W-1:1]) == 7'h00))
        else $error("right shift flags wrong");
    chk_zero_wrap: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_BUMP && f_now == 8'hFF |=> zero_flag)
        else $error("increment wrap zero wrong");
    chk_single_cycle: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op != OP_JUMP && !alu_bus.skip_hit |=> state == ST_EXEC
            && pc == PC_W'($past(pc) + 15'h0001))
        else $error("single cycle op stalled");
    chk_flush_hold: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        state == ST_FLUSH && !flush_is_skip |=> $stable(pc))
        else $error("jump target moved during flush");
    // Software writes may land during a flush, so they are left out here
    chk_flush_idle: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        state == ST_FLUSH && !I_WR |=> $stable(acc) && $stable(zero_flag)
            && $stable(carry_flag))
        else $error("flush cycle changed state");
    chk_or_file_dest: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_OR_FILE && I_INSTR[D_BIT] && !I_WR |=>
            file_mem[$past(f_addr)] == ($past(acc) | $past(f_now)) && $stable(acc))
        else $error("register OR to file wrong");
    chk_shl_dest: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHL && I_INSTR[D_BIT] |=>
            file_mem[$past(f_addr)] == {$past(f_now[DATA_W-2:0]), 1'b0})
        else $error("left shift result wrong");
    chk_shr_dest: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHR && !I_INSTR[D_BIT] |=> acc == {1'b0, $past(f_now[DATA_W-1:1])})
        else $error("right shift result wrong");
    chk_bump_flags: assert property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_BUMP |=> zero_flag == ($past(f_now) == 8'hFF)
            && $stable(carry_flag))
        else $error("increment flags wrong");

    cov_jump: cover property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_JUMP);
    cov_skip_taken: cover property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && alu_bus.skip_hit);
    cov_shift_carry: cover property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHL && f_now[DATA_W-1]);
    cov_file_dest: cover property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && to_file && op == OP_OR_FILE);
    cov_shift_right: cover property (@(posedge I_CLOCK) disable iff (!rst_n)
        exec && op == OP_SHR && f_now[0]);

endmodule : cbx_core

// *** bench/cbx_fetch_model.sv ***
// Program memory model that hands instruction words to the core
`timescale 1ns/1ps
module cbx_fetch_model
    import cbx_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_go,
    input  wire logic               i_ld,
    input  wire logic [7:0]         i_la,
    input  wire logic [INSTR_W-1:0] i_lw,
    input  wire logic [PC_W-1:0]    i_pc,
    output logic                    o_valid,
    output logic      [INSTR_W-1:0] o_instr
);
    // ========================================================================
    // Storage
    // Small window only; upper counter bits alias onto it
    logic [INSTR_W-1:0] mem [256];

    always_ff @(posedge i_clk) begin
        if (i_ld) begin
            mem[i_la] <= i_lw;
        end
    end

    // ========================================================================
    // Fetch
    // Word follows the counter, so it stays put for the whole cycle
    assign o_instr = mem[i_pc[7:0]];
    assign o_valid = i_go;
endmodule : cbx_fetch_model

// *** bench/tb_cpu_branch_inc_or_shift_ops.sv ***
// Self-checking bench for the execution core
`timescale 1ns/1ps
module tb_cpu_branch_inc_or_shift_ops;
    import cbx_pkg::*;
    typedef struct {
        logic [INSTR_W-1:0] w;
        logic [7:0]         av, fv, lat, xa, xf;
        logic [1:0]         fl, xfl;
        int                 inc;
    } cbx_row_t;
    localparam int                 CLK_PER_CYCLE = 4;
    localparam logic [INSTR_W-1:0] POISON        = 14'h38FF;
    logic               clk, nrst, go, ld, wr_s, rd_s, valid, zero, carry, flush, retire;
    logic [7:0]         addr, wdata, rdata, acc, la;
    logic [INSTR_W-1:0] instr, lw;
    logic [PC_W-1:0]    pc;
    int                 error_cnt = 0;
    int                 comparisons = 0;
    cbx_row_t           rows [14];

    cbx_core #(.CLK_PER_CYCLE(CLK_PER_CYCLE)) uut (.I_CLOCK(clk), .I_NRST(nrst),
        .I_INSTR_VALID(valid), .I_INSTR(instr), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_PC(pc), .O_ACC(acc),
        .O_ZERO(zero), .O_CARRY(carry), .O_FLUSH(flush), .O_RETIRE(retire));
    cbx_fetch_model fetch (.i_clk(clk), .i_go(go), .i_ld(ld), .i_la(la), .i_lw(lw),
        .i_pc(pc), .o_valid(valid), .o_instr(instr));

    // ========================================================================
    // Tasks
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] dv);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        dv = rdata;
    endtask : rd
    task automatic load(input logic [7:0] a, input logic [INSTR_W-1:0] wv);
        @(posedge clk);
        ld <= 1'b1;
        la <= a;
        lw <= wv;
        @(posedge clk);
        ld <= 1'b0;
    endtask : load
    task automatic wait_retire(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (retire !== 1'b1 && n < 40);
        chk("retire", 16'h0001, {15'h0000, retire});
    endtask : wait_retire
    task automatic tally_and_finish;
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ========================================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end

    // ========================================================================
    // Main sequence
    initial begin
        cbx_row_t        r;
        logic [PC_W-1:0] p, xp;
        logic [7:0]      d;
        int              n;
        nrst = 1'b0; go = 1'b0; ld = 1'b0; wr_s = 1'b0; rd_s = 1'b0;
        addr = 8'h00; wdata = 8'h00; la = 8'h00; lw = 14'h0000;
        rows = '{'{14'h0A85, 8'h12, 8'hFF, 8'h00, 8'h12, 8'h00, 2'h1, 2'h3, 1},
                 '{14'h0A7F, 8'h00, 8'h41, 8'h00, 8'h42, 8'h41, 2'h2, 2'h0, 1},
                 '{14'h0F80, 8'h33, 8'hFF, 8'h00, 8'h33, 8'h00, 2'h2, 2'h2, 2},
                 '{14'h0F05, 8'h00, 8'h7F, 8'h00, 8'h80, 8'h7F, 2'h1, 2'h1, 1},
                 '{14'h3800, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 2'h2, 1},
                 '{14'h38A5, 8'h5A, 8'h11, 8'h00, 8'hFF, 8'h11, 2'h2, 2'h0, 1},
                 '{14'h0485, 8'h0F, 8'h30, 8'h00, 8'h0F, 8'h3F, 2'h0, 2'h0, 1},
                 '{14'h0405, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 2'h0, 2'h2, 1},
                 '{14'h3585, 8'h00, 8'h81, 8'h00, 8'h00, 8'h02, 2'h0, 2'h1, 1},
                 '{14'h3505, 8'h00, 8'h80, 8'h00, 8'h00, 8'h80, 2'h0, 2'h3, 1},
                 '{14'h3685, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 2'h0, 2'h3, 1},
                 '{14'h3605, 8'h00, 8'hFE, 8'h00, 8'h7F, 8'hFE, 2'h1, 2'h0, 1},
                 '{14'h2FFF, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00, 2'h3, 2'h3, 0},
                 '{14'h2800, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 2'h0, 2'h0, 0}};
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("pc_rst", 16'h0000, {1'b0, pc});
        chk("acc_rst", 16'h0000, {8'h00, acc});
        rd(REG_FLAGS, d);
        chk("flags_rst", 16'h0000, {8'h00, d});
        rd(8'h90, d);
        chk("unmapped", 16'h0000, {8'h00, d});
        wr(REG_PC_LO, 8'h55);
        #1;
        chk("pc_ro", 16'h0000, {1'b0, pc});
        // Poison word after each row catches a skip or jump that still executes
        foreach (rows[i]) begin
            r = rows[i];
            wr(REG_ACC, r.av);
            wr({1'b0, r.w[6:0]}, r.fv);
            wr(REG_FLAGS, {6'h00, r.fl});
            wr(REG_LATCH, r.lat);
            p = pc;
            load(p[7:0], r.w);
            load(p[7:0] + 8'h01, POISON);
            @(posedge clk);
            go <= 1'b1;
            wait_retire(n);
            chk("flush", {15'h0000, r.inc != 1}, {15'h0000, flush});
            n = 0;
            while (flush === 1'b1 && n < 40) begin
                @(posedge clk);
                #1;
                n++;
            end
            chk("flush_len", (r.inc != 1) ? 16'(CLK_PER_CYCLE) : 16'h0000, 16'(n));
            @(posedge clk);
            go <= 1'b0;
            xp = (r.inc == 0) ? {r.lat[6:3], r.w[10:0]} : p + 15'(r.inc);
            #1;
            chk("pc", {1'b0, xp}, {1'b0, pc});
            chk("acc", {8'h00, r.xa}, {8'h00, acc});
            chk("flags", {14'h0000, r.xfl}, {14'h0000, zero, carry});
            rd({1'b0, r.w[6:0]}, d);
            chk("file", {8'h00, r.xf}, {8'h00, d});
        end
        wr(REG_ACC, 8'h00);
        p = pc;
        load(p[7:0], 14'h3801);
        load(p[7:0] + 8'h01, 14'h3802);
        @(posedge clk);
        go <= 1'b1;
        wait_retire(n);
        wait_retire(n);
        chk("spacing", 16'(CLK_PER_CYCLE), 16'(n));
        @(posedge clk);
        go <= 1'b0;
        #1;
        chk("acc_b2b", 16'h0003, {8'h00, acc});
        chk("pc_b2b", {1'b0, p + 15'h0002}, {1'b0, pc});
        tally_and_finish();
    end
endmodule : tb_cpu_branch_inc_or_shift_ops
